// [rfg_core.sv]
// Command FIFO and filter / gain bank selector for the interpolated-motion command
// Contract
// R1 - Bits 5:4 pick bypass, exponential, moving average
// R2 - Exponential filter uses exponential time constant
// R3 - Moving average uses moving average time
// R4 - New time constant adopted when both done
// R5 - Mode and bank from every interpolation command
// R6 - Bits 11:10 mode, bits 9:8 bank
// R7 - Fast feed mode forces gain bank 1
// R8 - Spindle mode uses bank bits directly
// R9 - Each bank holds four own gain parameters
// R10 - Cutting digit 0 enables predictive control
// R11 - Cutting digit 1 enables quadrant compensation
// R12 - Fast feed digit 0 selects feedforward kind
// R13 - Cutting mode forces gain bank 0
// R14 - Host picks mode per motion type
// R15 - Host uses bank 2/3 when tapping
// R16 - Host sends fresh reference every cycle
// R17 - Mode 3 uses bank 3, no functions
// R18 - Zero time constant passes reference through
//
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none

module rfg_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  // Pointers carry one extra bit so full and empty are told apart
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wp;
    logic [AW:0]         rp;
  } rfg_fifo_s;
  rfg_fifo_s st_reg, st_next;
  logic push, pop;

  if (D < 2 || (1 << AW) != D) begin : g_bad_depth
    $error("rfg_fifo depth must be a power of two");
  end

  // Flags come straight from the pointers
  always_comb begin
    out_valid = (st_reg.wp != st_reg.rp);
    in_ready  = (st_reg.wp[AW-1:0] != st_reg.rp[AW-1:0]) || (st_reg.wp[AW] == st_reg.rp[AW]);
    out_data  = st_reg.mem[st_reg.rp[AW-1:0]];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    st_next   = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp[AW-1:0]] = in_data;
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

module rfg_core
  import rfg_pkg::*;
#(
  parameter int FIFO_DEPTH = RFG_FIFO_DEPTH
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Classic Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Command stream from the fieldbus side
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [31:0] servo_cmd_control,
  input  wire logic [31:0] servo_cmd_io,
  input  wire logic [31:0] cmd_target_pos,
  // Motion status used to gate time constant updates
  input  wire logic        distribution_done,
  input  wire logic        positioning_done,
  // Filtered reference towards the position loop
  output logic             ref_valid,
  input  wire logic        ref_ready,
  output logic [31:0]      ref_pos,
  // Selected mode, bank, gains and functions
  output logic [1:0]       op_mode,
  output logic [1:0]       gain_bank,
  output logic [15:0]      speed_gain,
  output logic [15:0]      speed_integ,
  output logic [15:0]      pos_gain,
  output logic [15:0]      torque_filt,
  output logic             predictive_en,
  output logic             quadrant_comp_en,
  output logic [1:0]       feedforward_mode
);
  localparam int FW = 8 + 2 + 4 + 32;   // Code, filter select, mode/bank, position

  typedef struct packed {
    logic [12:0]         exp_tc;      // Software copies, adopted later
    logic [12:0]         ma_tc;
    logic [12:0]         exp_act;     // Time constants in force
    logic [12:0]         ma_act;
    logic [1:0]          cut_func;
    logic [1:0]          fast_func;
    logic [15:0][15:0]   gains;
    logic                ack;
    logic [31:0]         rdata;
    logic                rvalid;
    logic [31:0]         rpos;
    rfg_filt_e           fsel;
    rfg_mode_e           mode;
    logic [1:0]          bank;
    logic [47:0]         exp_acc;
    logic [15:0][31:0]   ring;
    logic [3:0]          wp;
    logic [35:0]         sum;
    logic [2:0]          ma_k;
    logic                ma_live;     // Ring holds a valid history
    logic [15:0]         sg, si, pg, tf;
    logic                pred, quad;
    logic [1:0]          ffm;
  } rfg_core_s;

  rfg_core_s   st_reg, st_next;
  logic        f_valid, f_ready;
  logic [FW-1:0] f_data;
  logic [7:0]  f_code;
  rfg_filt_e   f_sel;
  logic [1:0]  f_mode;
  logic [1:0]  f_bank;
  logic [31:0] f_pos;

  if (FIFO_DEPTH < 2) begin : g_bad_fifo
    $error("rfg_core needs a FIFO of at least two words");
  end

  // Smallest shift whose power of two covers the time constant, held at cap
  function automatic logic [3:0] shift_of(input logic [12:0] tc, input logic [3:0] cap);
    logic [3:0] k;
    k = 4'h0;
    for (int i = 0; i < 13; i++) begin
      if ((13'h0001 << k) < tc && k < cap) k = k + 4'h1;
    end
    return k;
  endfunction

  // Byte-lane merge of a write into a 32-bit image
  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // Buffer decouples bursty fieldbus delivery from the filter pace
  rfg_fifo #(
    .W (FW),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   ({cmd_code, servo_cmd_control[RFG_FSEL_LSB +: 2], servo_cmd_io[RFG_BANK_LSB +: 4], cmd_target_pos}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  assign f_code = f_data[45:38];
  assign f_sel  = rfg_filt_e'(f_data[37:36]); // R1
  assign f_mode = f_data[35:34];              // R6
  assign f_bank = f_data[33:32];              // R6
  assign f_pos  = f_data[31:0];
  // Stall the FIFO while the position loop has not taken the last output
  assign f_ready = !st_reg.rvalid || ref_ready;

  // Next-state logic: bus, time constant adoption, filter and selection
  always_comb begin
    logic [31:0]  wimg;
    logic [31:0]  old;
    logic [3:0]   gi;
    logic [12:0]  tcw;
    logic [3:0]   ke;
    logic [2:0]   km;
    logic [35:0]  s;
    logic [31:0]  y;
    logic [1:0]   bk;
    wimg    = 32'h0000_0000;
    old     = 32'h0000_0000;
    gi      = wb_adr_i[5:2];
    tcw     = 13'h0000;
    ke      = 4'h0;
    km      = 3'h0;
    s       = 36'h0_0000_0000;
    y       = 32'h0000_0000;
    bk      = 2'h0;
    st_next = st_reg;

    // Single-wait-state acknowledge, dropped the cycle after it is given
    st_next.ack = wb_cyc_i && wb_stb_i && !st_reg.ack;
    if (wb_cyc_i && wb_stb_i && !st_reg.ack) begin
      unique case (wb_adr_i)
        RFG_OFS_EXP_TC:    old = {19'h0, st_reg.exp_tc};
        RFG_OFS_MA_TIME:   old = {19'h0, st_reg.ma_tc};
        RFG_OFS_CUT_FUNC:  old = {30'h0, st_reg.cut_func};
        RFG_OFS_FAST_FUNC: old = {30'h0, st_reg.fast_func};
        RFG_OFS_STATUS:    old = {24'h0, st_reg.fsel, st_reg.mode, st_reg.bank, 1'b0, st_reg.rvalid};
        RFG_OFS_ACTIVE_TC: old = {3'h0, st_reg.ma_act, 3'h0, st_reg.exp_act};
        default: begin
          // Gain window answers, every other address reads zero
          if (wb_adr_i[7:6] == RFG_OFS_GAIN_BASE[7:6]) old = {16'h0, st_reg.gains[gi]};
          else old = 32'h0000_0000;
        end
      endcase
      st_next.rdata = old;
      if (wb_we_i) begin
        wimg = lanes(old, wb_dat_i, wb_sel_i);
        // Writes beyond the accepted range are held at the top value
        tcw  = (wimg[31:13] != 19'h0 || wimg[12:0] > RFG_TC_MAX) ? RFG_TC_MAX : wimg[12:0];
        unique case (wb_adr_i)
          RFG_OFS_EXP_TC:    st_next.exp_tc = tcw;
          RFG_OFS_MA_TIME:   st_next.ma_tc = tcw;
          RFG_OFS_CUT_FUNC:  st_next.cut_func = wimg[1:0];
          RFG_OFS_FAST_FUNC: st_next.fast_func = wimg[1:0];
          default: begin
            if (wb_adr_i[7:6] == RFG_OFS_GAIN_BASE[7:6]) st_next.gains[gi] = wimg[15:0]; // R9
          end
        endcase
      end
    end

    // Time constants only change hands once motion has fully settled
    if (distribution_done && positioning_done) begin // R4
      st_next.exp_act = st_reg.exp_tc; // R2
      st_next.ma_act  = st_reg.ma_tc;  // R3
    end

    // Output handshake: hold until the position loop takes it
    if (st_reg.rvalid && ref_ready) st_next.rvalid = 1'b0;

    // One command per pop; other codes are drained without effect
    if (f_valid && f_ready) begin
      if (f_code == RFG_INTERP_CODE) begin // R5
        ke = shift_of(st_reg.exp_act, 4'(RFG_EXP_SHIFT_MAX));
        km = 3'(shift_of(st_reg.ma_act, 4'(RFG_MA_SHIFT_MAX)));
        unique case (f_sel)
          RFG_FILT_EXP: begin
            // Fixed-point first-order lag; zero shift copies the input
            st_next.exp_acc = st_reg.exp_acc + 48'($signed({f_pos, 16'h0000} - st_reg.exp_acc) >>> ke); // R2 R18
            y = st_next.exp_acc[47:RFG_FRAC];
            st_next.ma_live = 1'b0;
          end
          RFG_FILT_MA: begin
            // Window is a power of two so no divider is needed
            if (!st_reg.ma_live || km != st_reg.ma_k) begin
              for (int i = 0; i < 16; i++) st_next.ring[i] = st_reg.rpos;
              s = 36'($signed(st_reg.rpos)) <<< km;
            end else begin
              s = st_reg.sum;
            end
            s = s + 36'($signed(f_pos)) - 36'($signed(st_next.ring[4'(st_reg.wp - (4'h1 << km))])); // R3
            st_next.ring[st_reg.wp] = f_pos;
            st_next.wp      = st_reg.wp + 4'h1;
            st_next.sum     = s;
            st_next.ma_k    = km;
            st_next.ma_live = 1'b1;
            y = 32'($signed(s) >>> km); // R18
            st_next.exp_acc = {y, 16'h0000};
          end
          default: begin
            // Bypass; the reserved code is treated the same
            y = f_pos; // R1
            st_next.exp_acc = {f_pos, 16'h0000};
            st_next.ma_live = 1'b0;
          end
        endcase
        st_next.rpos   = y;
        st_next.rvalid = 1'b1;
        st_next.fsel   = f_sel;
        st_next.mode   = rfg_mode_e'(f_mode);
        unique case (rfg_mode_e'(f_mode))
          RFG_MODE_CUT:     bk = 2'h0;   // R13
          RFG_MODE_FAST:    bk = 2'h1;   // R7
          RFG_MODE_SPINDLE: bk = f_bank; // R8
          RFG_MODE_RSVD:    bk = 2'h3;   // R17
        endcase
        st_next.bank = bk;
      end
    end

    // Gain set and functions follow the selection in force
    st_next.sg   = st_reg.gains[{st_reg.bank, RFG_PAR_SPEED_GAIN}]; // R9
    st_next.si   = st_reg.gains[{st_reg.bank, RFG_PAR_SPEED_INTG}];
    st_next.pg   = st_reg.gains[{st_reg.bank, RFG_PAR_POS_GAIN}];
    st_next.tf   = st_reg.gains[{st_reg.bank, RFG_PAR_TORQ_FILT}];
    st_next.pred = (st_reg.mode == RFG_MODE_CUT) && st_reg.cut_func[0]; // R10 R17
    st_next.quad = (st_reg.mode == RFG_MODE_CUT) && st_reg.cut_func[1]; // R11 R17
    // Code 3 of the fast feed digit has no meaning and acts as none
    st_next.ffm  = (st_reg.mode == RFG_MODE_FAST && st_reg.fast_func != 2'h3) ? st_reg.fast_func : 2'h0; // R12
  end

  // Single state register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg         <= '0;
      st_reg.exp_tc  <= RFG_TC_RESET;
      st_reg.ma_tc   <= RFG_TC_RESET;
      st_reg.exp_act <= RFG_TC_RESET;
      st_reg.ma_act  <= RFG_TC_RESET;
      st_reg.gains   <= {16{RFG_GAIN_RESET}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o         = st_reg.ack;
  assign wb_dat_o         = st_reg.rdata;
  assign ref_valid        = st_reg.rvalid;
  assign ref_pos          = st_reg.rpos;
  assign op_mode          = st_reg.mode;
  assign gain_bank        = st_reg.bank;
  assign speed_gain       = st_reg.sg;
  assign speed_integ      = st_reg.si;
  assign pos_gain         = st_reg.pg;
  assign torque_filt      = st_reg.tf;
  assign predictive_en    = st_reg.pred;
  assign quadrant_comp_en = st_reg.quad;
  assign feedforward_mode = st_reg.ffm;
endmodule

`default_nettype wire

// [rfg_core_asserts.sv]
// Port checker for the filter and gain bank selector
`timescale 1ns/10ps
`default_nettype none
module rfg_core_asserts
  import rfg_pkg::*;
#(
  parameter int FIFO_DEPTH = RFG_FIFO_DEPTH
) (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        ref_valid,
  input wire logic        ref_ready,
  input wire logic [31:0] ref_pos,
  input wire logic [1:0]  op_mode,
  input wire logic [1:0]  gain_bank,
  input wire logic        predictive_en,
  input wire logic        quadrant_comp_en,
  input wire logic [1:0]  feedforward_mode
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("Bus request not answered");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("Bus answer longer than one cycle");
  // A waiting sample must not move under the consumer
  property p_ref_hold; ref_valid && !ref_ready |=> ref_valid && $stable(ref_pos) && $stable(gain_bank); endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("Reference sample changed while waiting");
  // Past reset guard: a one-edge reset leaves an old sample behind
  property p_mode_cause; !$past(sys_rst) && ($changed(op_mode) || $changed(gain_bank)) |-> ref_valid; endproperty
  a_mode_cause: assert property (p_mode_cause) else $error("Mode changed without a command");
  property p_cut_bank; op_mode == RFG_MODE_CUT |-> gain_bank == 2'h0; endproperty
  a_cut_bank: assert property (p_cut_bank) else $error("Cutting mode not on bank 0");
  property p_fast_bank; op_mode == RFG_MODE_FAST |-> gain_bank == 2'h1; endproperty
  a_fast_bank: assert property (p_fast_bank) else $error("Fast feed not on bank 1");
  property p_rsvd_bank; op_mode == RFG_MODE_RSVD |-> gain_bank == 2'h3; endproperty
  a_rsvd_bank: assert property (p_rsvd_bank) else $error("Reserved mode not on bank 3");
  // Function enables lag the mode by one cycle
  property p_rsvd_off; op_mode == RFG_MODE_RSVD |=> !predictive_en && !quadrant_comp_en && !feedforward_mode; endproperty
  a_rsvd_off: assert property (p_rsvd_off) else $error("Function on in reserved mode");
  property p_cut_only; op_mode != RFG_MODE_CUT |=> !predictive_en && !quadrant_comp_en; endproperty
  a_cut_only: assert property (p_cut_only) else $error("Cutting function outside cutting");
  property p_fast_only; op_mode != RFG_MODE_FAST |=> feedforward_mode == 2'h0; endproperty
  a_fast_only: assert property (p_fast_only) else $error("Feedforward outside fast feed");
  c_spindle: cover property (op_mode == RFG_MODE_SPINDLE && gain_bank == 2'h3);
  c_full: cover property (cmd_valid && !cmd_ready);
  c_stall: cover property (ref_valid && !ref_ready ##1 ref_valid && ref_ready);
endmodule
bind rfg_core rfg_core_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clk_sys, .sys_rst, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .cmd_valid, .cmd_ready, .ref_valid, .ref_ready, .ref_pos, .op_mode, .gain_bank, .predictive_en,
  .quadrant_comp_en, .feedforward_mode);
`default_nettype wire

// [rfg_core_tb.sv]
// Self-checking bench for the filter and gain bank selector
`timescale 1ns/10ps
`default_nettype none
module rfg_core_tb
  import rfg_pkg::*;
;
  typedef struct packed {logic [31:0] pos; logic [1:0] m, b; logic [63:0] g; logic [3:0] fn;} rfg_exp_s;
  logic        clk_sys = 1'b0, sys_rst = 1'b1, cyc = 1'b0, we = 1'b0, go = 1'b0, rr_rand = 1'b0, pend_v = 1'b0;
  logic        ref_ready = 1'b0, distribution_done = 1'b0, positioning_done = 1'b0;
  logic [7:0]  adr = 8'h00, go_code = 8'h00, cmd_code;
  logic [5:0]  go_sel = 6'h00;
  logic [31:0] wdat = '0, go_pos = '0, p, wb_dat_o, servo_cmd_control, servo_cmd_io, cmd_target_pos, ref_pos;
  logic        wb_ack_o, cmd_valid, cmd_ready, ref_valid, predictive_en, quadrant_comp_en;
  logic [1:0]  op_mode, gain_bank, feedforward_mode, cut_set = 2'h0, fast_set = 2'h0;
  logic [15:0] speed_gain, speed_integ, pos_gain, torque_filt, gv [16];
  rfg_exp_s    q [$], pend;  // Notes of expected samples
  logic [31:0] rq [$];       // Notes of expected read data
  int          error_cnt = 0, check_count = 0, acc_cnt = 0;
  integer      seed = 32'had44;
  rfg_core #(.FIFO_DEPTH(RFG_FIFO_DEPTH)) DUT (.clk_sys, .sys_rst, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o, .cmd_valid, .cmd_ready, .cmd_code,
    .servo_cmd_control, .servo_cmd_io, .cmd_target_pos, .distribution_done, .positioning_done, .ref_valid,
    .ref_ready, .ref_pos, .op_mode, .gain_bank, .speed_gain, .speed_integ, .pos_gain, .torque_filt,
    .predictive_en, .quadrant_comp_en, .feedforward_mode);
  rfg_host_model HOST (.clk_sys, .sys_rst, .go, .go_code, .go_sel, .go_pos, .cmd_ready, .cmd_valid, .cmd_code,
    .servo_cmd_control, .servo_cmd_io, .cmd_target_pos);
  initial forever #50 clk_sys = ~clk_sys;
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("Checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Classic single cycle; held until the answer is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin @(posedge clk_sys); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin error_cnt++; complete_run(); end
    cyc <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  // Notes the expected sample, then offers the command until taken
  task automatic send(input logic [7:0] c, input logic [5:0] s, input logic [31:0] ps, input logic [31:0] ep);
    int n;
    rfg_exp_s e;
    n = 0;
    e.pos = ep; e.m = s[3:2];
    e.b = (s[3:2] == 2'h2) ? s[1:0] : s[3:2];
    e.g = {gv[{e.b, 2'h0}], gv[{e.b, 2'h1}], gv[{e.b, 2'h2}], gv[{e.b, 2'h3}]};
    e.fn = {s[3:2] == 2'h0 && cut_set[0], s[3:2] == 2'h0 && cut_set[1], (s[3:2] == 2'h1) ? 2'(fast_set % 3) : 2'h0};
    if (c == RFG_INTERP_CODE) q.push_back(e);
    go <= 1'b1; go_code <= c; go_sel <= s; go_pos <= ps;
    @(posedge clk_sys);
    go <= 1'b0;
    do begin @(posedge clk_sys); n++; end while ((cmd_valid & cmd_ready) !== 1'b1 && n < 500);
    if (n >= 500) begin error_cnt++; complete_run(); end
  endtask
  task automatic drain;
    int n;
    n = 0;
    while ((q.size() != 0 || pend_v) && n < 3000) begin @(posedge clk_sys); n++; end
    if (n >= 3000) begin error_cnt++; complete_run(); end
  endtask
  // Random consumer stalls and acceptance count
  always @(posedge clk_sys) begin
    if (rr_rand) ref_ready <= 1'($random(seed));
    if ((cmd_valid & cmd_ready) === 1'b1) acc_cnt++;
  end
  // Takes the oldest note whenever the consumer takes a result
  always @(posedge clk_sys) begin
    if (pend_v) begin
      check(64'({speed_gain, speed_integ, pos_gain, torque_filt}), pend.g);
      check(64'({predictive_en, quadrant_comp_en, feedforward_mode}), 64'(pend.fn));
      pend_v = 1'b0;
    end
    if ((ref_valid & ref_ready) === 1'b1 && q.size() == 0) check(64'h1, 64'h0);
    else if ((ref_valid & ref_ready) === 1'b1) begin
      pend = q.pop_front();
      pend_v = 1'b1;
      check(64'(ref_pos), 64'(pend.pos));
      check(64'({op_mode, gain_bank}), 64'({pend.m, pend.b}));
    end
    if (wb_ack_o === 1'b1 && !we) check(64'(wb_dat_o), 64'(rq.pop_front()));
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(RFG_OFS_CUT_FUNC, 32'h0);
    wb(1'b1, 8'h30, 32'hffffffff);
    rd(8'h30, 32'h0); // Unmapped place reads zero
    wb(1'b1, RFG_OFS_EXP_TC, 32'h1fff);
    wb(1'b1, RFG_OFS_MA_TIME, 32'h2);
    rd(RFG_OFS_ACTIVE_TC, 32'h0);
    distribution_done <= 1'b1;
    rd(RFG_OFS_ACTIVE_TC, 32'h0);
    positioning_done <= 1'b1;
    @(posedge clk_sys); // Let the adoption edge pass before the read is taken
    rd(RFG_OFS_ACTIVE_TC, {16'h0002, 3'h0, RFG_TC_MAX});
    rd(RFG_OFS_EXP_TC, {19'h0, RFG_TC_MAX});
    wb(1'b1, RFG_OFS_EXP_TC, 32'h2);
    for (int i = 0; i < 16; i++) begin
      gv[i] = 16'($random(seed));
      wb(1'b1, RFG_OFS_GAIN_BASE + 8'(i * 4), {16'h0, gv[i]});
    end
    rd(RFG_OFS_GAIN_BASE + 8'h3c, {16'h0, gv[15]});
    // Exponential halves the gap, moving average over two samples
    ref_ready <= 1'b1;
    send(RFG_INTERP_CODE, 6'h10, 32'h40, 32'h20);
    send(RFG_INTERP_CODE, 6'h10, 32'h40, 32'h30);
    send(RFG_INTERP_CODE, 6'h20, 32'h80, 32'h58);
    send(RFG_INTERP_CODE, 6'h20, 32'h80, 32'h80);
    p = $random(seed);
    send(RFG_INTERP_CODE, 6'h30, p, p);
    wb(1'b1, RFG_OFS_EXP_TC, 32'h0);
    wb(1'b1, RFG_OFS_MA_TIME, 32'h0);
    for (int k = 1; k < 3; k++) begin
      p = $random(seed);
      send(RFG_INTERP_CODE, 6'(k * 16), p, p);
    end
    // Every mode and bank code under every function digit; 0, 5, 10 and 11 are the host encodings
    rr_rand <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      drain();
      cut_set = 2'(s);
      fast_set = 2'(s);
      wb(1'b1, RFG_OFS_CUT_FUNC, 32'(s));
      wb(1'b1, RFG_OFS_FAST_FUNC, 32'(s));
      for (int g = 0; g < 16; g++) begin
        p = $random(seed);
        send(RFG_INTERP_CODE, 6'(g), p, p);
      end
      send(8'h35, 6'h0b, p, p);
    end
    drain();
    rr_rand <= 1'b0;
    @(posedge clk_sys);
    ref_ready <= 1'b0;
    acc_cnt = 0;
    // Consumer stalls until the buffer refuses, then drains it
    fork
      begin
        repeat (60) @(posedge clk_sys);
        check(64'(cmd_ready), 64'h0);
        check(64'(acc_cnt), 64'(RFG_FIFO_DEPTH + 1));
        ref_ready <= 1'b1;
      end
    join_none
    for (int i = 0; i < 20; i++) begin
      p = $random(seed);
      send(RFG_INTERP_CODE, 6'h05, p, p);
    end
    drain();
    complete_run();
  end
endmodule
`default_nettype wire

// [rfg_host_model.sv]
// Host controller model pushing interpolated-motion commands
`timescale 1ns/10ps
`default_nettype none
module rfg_host_model (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        go,
  input  wire logic [7:0]  go_code,
  input  wire logic [5:0]  go_sel,
  input  wire logic [31:0] go_pos,
  input  wire logic        cmd_ready,
  output logic             cmd_valid,
  output logic [7:0]       cmd_code,
  output logic [31:0]      servo_cmd_control,
  output logic [31:0]      servo_cmd_io,
  output logic [31:0]      cmd_target_pos
);
  logic         v = 1'b0; // Command offered
  logic [103:0] f = '0;   // Code, control, io and position words
  assign cmd_valid = v;
  assign {cmd_code, servo_cmd_control, servo_cmd_io, cmd_target_pos} = f;
  // Holds an offer until taken; spare bits carry noise so only the fields decide
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      v <= 1'b0;
    end else if (go) begin
      v <= 1'b1;
      f <= {go_code, go_pos[31:6], go_sel[5:4], go_pos[3:0], go_pos[31:12], go_sel[3:0], go_pos[7:0], go_pos};
    end else if (v && cmd_ready) begin
      v <= 1'b0;
      f <= ~f; // Released lines show no stale value
    end
  end
endmodule
`default_nettype wire

// [rfg_pkg.sv]
// Constants and types shared by the reference filter and gain bank selector
package rfg_pkg;
  localparam logic [7:0]  RFG_INTERP_CODE    = 8'h34;   // Interpolated-motion command code
  localparam int          RFG_FSEL_LSB       = 4;       // Filter select field in control word
  localparam int          RFG_BANK_LSB       = 8;       // Gain bank field in io word
  localparam int          RFG_MODE_LSB       = 10;      // Operation mode field in io word
  localparam logic [12:0] RFG_TC_MAX         = 13'h13ec; // 5100 steps of 0.1 ms
  localparam logic [12:0] RFG_TC_RESET       = 13'h0000;
  localparam int          RFG_EXP_SHIFT_MAX  = 13;
  localparam int          RFG_MA_SHIFT_MAX   = 4;
  localparam int          RFG_FRAC           = 16;      // Fraction bits of exponential accumulator
  localparam int          RFG_FIFO_DEPTH     = 16;
  // Register byte offsets
  localparam logic [7:0]  RFG_OFS_EXP_TC     = 8'h00;
  localparam logic [7:0]  RFG_OFS_MA_TIME    = 8'h04;
  localparam logic [7:0]  RFG_OFS_CUT_FUNC   = 8'h08;
  localparam logic [7:0]  RFG_OFS_FAST_FUNC  = 8'h0c;
  localparam logic [7:0]  RFG_OFS_STATUS     = 8'h10;
  localparam logic [7:0]  RFG_OFS_ACTIVE_TC  = 8'h14;
  localparam logic [7:0]  RFG_OFS_GAIN_BASE  = 8'h40;   // 16 words: index = bank*4 + parameter
  localparam logic [1:0]  RFG_PAR_SPEED_GAIN = 2'h0;
  localparam logic [1:0]  RFG_PAR_SPEED_INTG = 2'h1;
  localparam logic [1:0]  RFG_PAR_POS_GAIN   = 2'h2;
  localparam logic [1:0]  RFG_PAR_TORQ_FILT  = 2'h3;
  localparam logic [15:0] RFG_GAIN_RESET     = 16'h0000;

  typedef enum logic [1:0] {
    RFG_FILT_NONE = 2'b00,
    RFG_FILT_EXP  = 2'b01,
    RFG_FILT_MA   = 2'b10,
    RFG_FILT_RSVD = 2'b11
  } rfg_filt_e;

  typedef enum logic [1:0] {
    RFG_MODE_CUT     = 2'b00,
    RFG_MODE_FAST    = 2'b01,
    RFG_MODE_SPINDLE = 2'b10,
    RFG_MODE_RSVD    = 2'b11
  } rfg_mode_e;
endpackage
